/* logic/gauge_cfg_bank.v */
// configuration register bank of a one-cell fuel gauge, reached as 16-bit words over I2C
// assumes: gauging core supplies fine level, voltage samples and thermistor conversions
//
// What this block does
// - read-only 16-bit version register with a management code.
// - profile select holds one of five profiles, values zero to four.
// - profile write re-initialises relative level from that profile and first voltage.
// - read-only register identifying the installed profile set.
// - fit register upper byte adjusts charging, lower byte discharging, independent.
// - termination rate in 0.01C; above 2 relative level tops out earlier.
// - full-side offset derived from selected profile and termination rate.
// - low voltage, fine above offset, warm cell: copy fine level into offset.
// - empty voltage of zero disables the automatic offset capture.
// - relative level reads 0% when fine level equals the empty offset.
// - empty offset takes host writes as well as automatic captures.
// - source bit 0: host writes temperature; 1: device loads it from thermistor.
// - writable thermistor B-constant used by the temperature conversion.
// - thermistor pull-up switched on only around each periodic measurement.
// - wait 0.167 us times (200 plus settle value) before sampling.
// - settle delay resets to 0x001E; raise it for a capacitor across thermistor.
// - write data discarded unless the write word carries a valid CRC-8.
// - termination rate accepts 0x0002 to 0x001E, resets to 0x0002.
`timescale 1ns/1ps
`default_nettype none
`include "gauge_cfg_regs.vh"
module gauge_cfg_bank #(
   parameter [6:0] SLAVE_ADDR = 7'h0B,
   parameter [15:0] VERSION_CODE = 16'h0001, // arbitrary value
   parameter [15:0] PROFILES_ID = 16'h0001, // arbitrary value
   parameter [39:0] FULL_SLOPE = 40'h0A0A_0A0A_0A,
   parameter [31:0] THERM_PERIOD = `THERM_PERIOD_CYC
) (
   // clock and reset
   input wire CLK_I,
   input wire RESET_N_I,
   // two-wire host bus
   input wire SCL_I,
   input wire SDA_I,
   output wire SDA_O,
   output wire SDA_OE_O,
   // gauging core
   input wire [15:0] CELL_VOLTAGE_I,
   input wire VOLTAGE_VALID_I,
   input wire [15:0] FINE_LEVEL_I,
   output reg [2:0] PROFILE_O,
   output reg REINIT_O,
   output reg [15:0] REINIT_VOLTAGE_O,
   output reg [7:0] CHARGE_FIT_O,
   output reg [7:0] DISCHARGE_FIT_O,
   output reg [15:0] FULL_OFFSET_O,
   output reg [15:0] EMPTY_OFFSET_O,
   output reg [6:0] RELATIVE_LEVEL_O,
   output reg [15:0] CELL_TEMP_O,
   // thermistor
   input wire THERM_DONE_I,
   input wire [15:0] THERM_TEMP_I,
   output reg [15:0] THERM_B_O,
   output reg PULLUP_EN_O,
   output reg SAMPLE_REQ_O
);
   localparam [1:0] T_IDLE = 2'd0;
   localparam [1:0] T_SETTLE = 2'd1;
   localparam [1:0] T_CONV = 2'd2;
   localparam [15:0] FIT_RST = `RST_FIT_ADJ;
   localparam [23:0] REL_MAX = `REL_FULL;

   function [7:0] crc8_step;
      input [7:0] crc;
      input [7:0] data;
      integer i;
      reg [7:0] c;
      begin
         c = crc ^ data;
         for (i = 0; i < 8; i = i + 1) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
         end
         crc8_step = c;
      end
   endfunction

   wire start;
   wire stop;
   wire rx_valid;
   wire rx_first;
   wire [7:0] rx_byte;
   wire tx_done;
   reg [7:0] tx_byte;
   reg busy_r;
   reg [7:0] crc_r;
   reg [2:0] idx_r;
   reg [1:0] rd_idx_r;
   reg [7:0] cmd_r;
   reg [7:0] lo_r;
   reg [15:0] wdata_r;
   reg [15:0] rdata_r;
   reg wr_go_r;
   reg [15:0] settle_r;
   reg [15:0] term_r;
   reg [15:0] empty_v_r;
   reg temp_src_r;
   reg first_seen_r;
   reg [1:0] tstate_r;
   reg [31:0] tcnt_r;
   reg [15:0] rd_word;

   assign SDA_O = 1'b0; // open drain: only the enable ever changes

   i2c_byte_port #(
      .SLAVE_ADDR(SLAVE_ADDR)
   ) u_port (
      .clk_i(CLK_I),
      .rst_n_i(RESET_N_I),
      .scl_i(SCL_I),
      .sda_i(SDA_I),
      .tx_byte_i(tx_byte),
      .sda_oe_o(SDA_OE_O),
      .start_o(start),
      .stop_o(stop),
      .rx_valid_o(rx_valid),
      .rx_first_o(rx_first),
      .rx_byte_o(rx_byte),
      .tx_done_o(tx_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // read multiplexer; undefined codes read zero
   always @* begin
      case (rx_byte)
         `CMD_THERM_B: rd_word = THERM_B_O;
         `CMD_CELL_TEMP: rd_word = CELL_TEMP_O;
         `CMD_FIT_ADJ: rd_word = {CHARGE_FIT_O, DISCHARGE_FIT_O};
         `CMD_SETTLE: rd_word = settle_r;
         `CMD_VERSION: rd_word = VERSION_CODE;
         `CMD_PROFILE: rd_word = {13'h0000, PROFILE_O};
         `CMD_TEMP_SRC: rd_word = {15'h0000, temp_src_r};
         `CMD_PROFILES_ID: rd_word = PROFILES_ID;
         `CMD_TERM_RATE: rd_word = term_r;
         `CMD_EMPTY_V: rd_word = empty_v_r;
         `CMD_EMPTY_OFF: rd_word = EMPTY_OFFSET_O;
         default: rd_word = 16'h0000;
      endcase
   end

   always @* begin
      case (rd_idx_r)
         2'd0: tx_byte = rdata_r[7:0];
         2'd1: tx_byte = rdata_r[15:8];
         2'd2: tx_byte = crc_r;
         default: tx_byte = 8'hFF;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // word transaction: address, command, low, high, crc
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         busy_r <= 1'b0;
         crc_r <= 8'h00;
         idx_r <= 3'd0;
         rd_idx_r <= 2'd0;
         cmd_r <= 8'h00;
         lo_r <= 8'h00;
         wdata_r <= 16'h0000;
         rdata_r <= 16'h0000;
         wr_go_r <= 1'b0;
      end else begin
         wr_go_r <= 1'b0;
         if (start) begin
            // a repeated start keeps the running crc
            if (!busy_r) begin
               crc_r <= 8'h00;
            end
            busy_r <= 1'b1;
            idx_r <= 3'd0;
            rd_idx_r <= 2'd0;
         end else if (stop) begin
            busy_r <= 1'b0;
         end else if (rx_valid) begin
            crc_r <= crc8_step(crc_r, rx_byte);
            if (rx_first) begin
               idx_r <= rx_byte[0] ? 3'd5 : 3'd1;
            end else begin
               case (idx_r)
                  3'd1: begin
                     cmd_r <= rx_byte;
                     rdata_r <= rd_word;
                  end
                  3'd2: lo_r <= rx_byte;
                  3'd3: wdata_r <= {rx_byte, lo_r};
                  3'd4: wr_go_r <= (rx_byte == crc_r);
                  default: ;
               endcase
               if (idx_r < 3'd5) begin
                  idx_r <= idx_r + 3'd1;
               end
            end
         end else if (tx_done) begin
            crc_r <= crc8_step(crc_r, tx_byte);
            if (rd_idx_r != 2'd3) begin
               rd_idx_r <= rd_idx_r + 2'd1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register writes and automatic offset capture
   wire cap_ok = VOLTAGE_VALID_I && empty_v_r != 16'h0000
      && CELL_VOLTAGE_I < empty_v_r && FINE_LEVEL_I > EMPTY_OFFSET_O
      && CELL_TEMP_O > `TEMP_ZERO_C;

   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         THERM_B_O <= `RST_THERM_B;
         CELL_TEMP_O <= `RST_CELL_TEMP;
         CHARGE_FIT_O <= FIT_RST[`FIT_CHG_MSB:`FIT_CHG_LSB];
         DISCHARGE_FIT_O <= FIT_RST[`FIT_DIS_MSB:`FIT_DIS_LSB];
         settle_r <= `RST_SETTLE;
         PROFILE_O <= `RST_PROFILE;
         temp_src_r <= 1'b0;
         term_r <= `RST_TERM_RATE;
         empty_v_r <= `RST_EMPTY_V;
         EMPTY_OFFSET_O <= `RST_EMPTY_OFF;
         REINIT_O <= 1'b0;
         REINIT_VOLTAGE_O <= 16'h0000;
         first_seen_r <= 1'b0;
      end else begin
         REINIT_O <= 1'b0;
         if (VOLTAGE_VALID_I && !first_seen_r) begin
            first_seen_r <= 1'b1;
            REINIT_VOLTAGE_O <= CELL_VOLTAGE_I;
         end
         if (wr_go_r) begin
            case (cmd_r)
               `CMD_THERM_B: THERM_B_O <= wdata_r;
               `CMD_CELL_TEMP: if (!temp_src_r) CELL_TEMP_O <= wdata_r;
               `CMD_FIT_ADJ: begin
                  CHARGE_FIT_O <= wdata_r[`FIT_CHG_MSB:`FIT_CHG_LSB];
                  DISCHARGE_FIT_O <= wdata_r[`FIT_DIS_MSB:`FIT_DIS_LSB];
               end
               `CMD_SETTLE: settle_r <= wdata_r;
               `CMD_PROFILE: if (wdata_r <= `PROFILE_MAX) begin
                  PROFILE_O <= wdata_r[2:0];
                  REINIT_O <= 1'b1;
               end
               `CMD_TEMP_SRC: temp_src_r <= wdata_r[`TEMP_SRC_BIT];
               `CMD_TERM_RATE:
                  if (wdata_r >= `TERM_RATE_MIN && wdata_r <= `TERM_RATE_MAX)
                     term_r <= wdata_r;
               `CMD_EMPTY_V: empty_v_r <= wdata_r;
               `CMD_EMPTY_OFF: EMPTY_OFFSET_O <= wdata_r;
               default: ;
            endcase
         end
         // capture after the host write so a same-cycle capture wins
         if (cap_ok) begin
            EMPTY_OFFSET_O <= FINE_LEVEL_I;
         end
         if (tstate_r == T_CONV && THERM_DONE_I && temp_src_r) begin
            CELL_TEMP_O <= THERM_TEMP_I;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // charge level rescaling between empty offset and full-side offset
   wire [15:0] slope = {8'h00, FULL_SLOPE[PROFILE_O * 8 +: 8]};
   wire [15:0] full_off = (term_r - `TERM_RATE_MIN) * slope;
   wire [15:0] top = (full_off >= `FINE_FULL) ? 16'h0000 : `FINE_FULL - full_off;
   wire [23:0] num = {8'h00, FINE_LEVEL_I - EMPTY_OFFSET_O} * 24'h00_0064;
   wire [23:0] den = {8'h00, top - EMPTY_OFFSET_O};
   wire [23:0] quo = (den == 24'h00_0000) ? 24'h00_0000 : num / den;

   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         FULL_OFFSET_O <= 16'h0000;
         RELATIVE_LEVEL_O <= 7'h00;
      end else begin
         FULL_OFFSET_O <= full_off;
         if (FINE_LEVEL_I <= EMPTY_OFFSET_O) begin
            RELATIVE_LEVEL_O <= 7'h00;
         end else if (FINE_LEVEL_I >= top || quo >= `REL_FULL) begin
            RELATIVE_LEVEL_O <= REL_MAX[6:0];
         end else begin
            RELATIVE_LEVEL_O <= quo[6:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // periodic thermistor measurement; pull-up powered only while measuring
   wire [31:0] settle_cyc = `SETTLE_CYC({16'h0000, settle_r});

   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         tstate_r <= T_IDLE;
         tcnt_r <= 32'h0000_0000;
         PULLUP_EN_O <= 1'b0;
         SAMPLE_REQ_O <= 1'b0;
      end else begin
         SAMPLE_REQ_O <= 1'b0;
         if (!temp_src_r) begin
            tstate_r <= T_IDLE;
            tcnt_r <= 32'h0000_0000;
            PULLUP_EN_O <= 1'b0;
         end else begin
            case (tstate_r)
               T_IDLE: if (tcnt_r == 32'h0000_0000) begin
                  PULLUP_EN_O <= 1'b1;
                  tcnt_r <= settle_cyc;
                  tstate_r <= T_SETTLE;
               end else begin
                  tcnt_r <= tcnt_r - 32'h0000_0001;
               end
               T_SETTLE: if (tcnt_r <= 32'h0000_0001) begin
                  SAMPLE_REQ_O <= 1'b1;
                  tstate_r <= T_CONV;
               end else begin
                  tcnt_r <= tcnt_r - 32'h0000_0001;
               end
               T_CONV: if (THERM_DONE_I) begin
                  PULLUP_EN_O <= 1'b0;
                  tcnt_r <= THERM_PERIOD - 32'h0000_0001;
                  tstate_r <= T_IDLE;
               end
               default: tstate_r <= T_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* logic/gauge_cfg_regs.vh */
// register map, reset values and timing constants of the gauge configuration bank
// assumes: included by bare name from the design files under logic/
`ifndef GAUGE_CFG_REGS_VH
`define GAUGE_CFG_REGS_VH

// command codes
`define CMD_THERM_B 8'h06
`define CMD_CELL_TEMP 8'h08
`define CMD_FIT_ADJ 8'h0B
`define CMD_SETTLE 8'h0C
`define CMD_VERSION 8'h11
`define CMD_PROFILE 8'h12
`define CMD_TEMP_SRC 8'h16
`define CMD_PROFILES_ID 8'h1A
`define CMD_TERM_RATE 8'h1C
`define CMD_EMPTY_V 8'h1D
`define CMD_EMPTY_OFF 8'h1E

// reset values
`define RST_THERM_B 16'h0D34
`define RST_CELL_TEMP 16'h0BA6
`define RST_FIT_ADJ 16'h0000
`define RST_SETTLE 16'h001E
`define RST_PROFILE 3'h0
`define RST_TERM_RATE 16'h0002
`define RST_EMPTY_V 16'h0000
`define RST_EMPTY_OFF 16'h0000

// value limits and fields
`define PROFILE_MAX 16'h0004
`define TERM_RATE_MIN 16'h0002
`define TERM_RATE_MAX 16'h001E
`define TEMP_ZERO_C 16'h0AAC
`define FINE_FULL 16'h03E8
`define REL_FULL 24'h00_0064
`define TEMP_SRC_BIT 0
`define FIT_CHG_MSB 15
`define FIT_CHG_LSB 8
`define FIT_DIS_MSB 7
`define FIT_DIS_LSB 0

// timing: settle delay is unit * (base + register), least time, so rounded up
`define CLK_PERIOD_NS 20
`define CLK_KHZ 50000
`define SETTLE_UNIT_NS 167
`define SETTLE_BASE 200
`define SETTLE_CYC(v) ((((`SETTLE_BASE + (v)) * `SETTLE_UNIT_NS) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define THERM_PERIOD_MS 1000
`define THERM_PERIOD_CYC (`THERM_PERIOD_MS * `CLK_KHZ)

`endif

/* logic/i2c_byte_port.v */
// byte level two-wire slave: start/stop detection, address match, ack, shift in and out
// assumes: scl and sda already synchronous to clk_i; no clock stretching
`timescale 1ns/1ps
`default_nettype none
module i2c_byte_port #(
   parameter [6:0] SLAVE_ADDR = 7'h0B
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire scl_i,
   input wire sda_i,
   input wire [7:0] tx_byte_i,
   output reg sda_oe_o,
   output reg start_o,
   output reg stop_o,
   output reg rx_valid_o,
   output reg rx_first_o,
   output reg [7:0] rx_byte_o,
   output reg tx_done_o
);
   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_RX = 3'd1;
   localparam [2:0] S_ACK1 = 3'd2;
   localparam [2:0] S_ACK2 = 3'd3;
   localparam [2:0] S_TX = 3'd4;
   localparam [2:0] S_TXACK = 3'd5;
   localparam [2:0] S_TXLD = 3'd6;

   reg [2:0] state_r;
   reg scl_q_r;
   reg sda_q_r;
   reg [2:0] bitc_r;
   reg [7:0] sh_r;
   reg first_r;
   reg rw_r;
   wire rise = ~scl_q_r & scl_i;
   wire fall = scl_q_r & ~scl_i;
   wire st = scl_q_r & scl_i & sda_q_r & ~sda_i;
   wire sp = scl_q_r & scl_i & ~sda_q_r & sda_i;
   wire [7:0] shifted = {sh_r[6:0], sda_i};

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= S_IDLE;
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
         bitc_r <= 3'd0;
         sh_r <= 8'h00;
         first_r <= 1'b0;
         rw_r <= 1'b0;
         sda_oe_o <= 1'b0;
         start_o <= 1'b0;
         stop_o <= 1'b0;
         rx_valid_o <= 1'b0;
         rx_first_o <= 1'b0;
         rx_byte_o <= 8'h00;
         tx_done_o <= 1'b0;
      end else begin
         scl_q_r <= scl_i;
         sda_q_r <= sda_i;
         start_o <= st;
         stop_o <= sp;
         rx_valid_o <= 1'b0;
         tx_done_o <= 1'b0;
         if (st) begin
            state_r <= S_RX;
            bitc_r <= 3'd0;
            first_r <= 1'b1;
            sda_oe_o <= 1'b0;
         end else if (sp) begin
            state_r <= S_IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            case (state_r)
               S_RX: if (rise) begin
                  sh_r <= shifted;
                  bitc_r <= bitc_r + 3'd1;
                  if (bitc_r == 3'd7) begin
                     // foreign address: stay off the bus until the next start
                     if (first_r && shifted[7:1] != SLAVE_ADDR) begin
                        state_r <= S_IDLE;
                     end else begin
                        rx_valid_o <= 1'b1;
                        rx_first_o <= first_r;
                        rx_byte_o <= shifted;
                        if (first_r) begin
                           rw_r <= shifted[0];
                        end
                        state_r <= S_ACK1;
                     end
                  end
               end
               S_ACK1: if (fall) begin
                  sda_oe_o <= 1'b1;
                  state_r <= S_ACK2;
               end
               S_ACK2: if (fall) begin
                  bitc_r <= 3'd0;
                  if (first_r && rw_r) begin
                     sh_r <= tx_byte_i;
                     sda_oe_o <= ~tx_byte_i[7];
                     state_r <= S_TX;
                  end else begin
                     sda_oe_o <= 1'b0;
                     state_r <= S_RX;
                  end
                  first_r <= 1'b0;
               end
               S_TX: if (fall) begin
                  if (bitc_r == 3'd7) begin
                     sda_oe_o <= 1'b0;
                     state_r <= S_TXACK;
                  end else begin
                     sh_r <= {sh_r[6:0], 1'b0};
                     sda_oe_o <= ~sh_r[6];
                     bitc_r <= bitc_r + 3'd1;
                  end
               end
               S_TXACK: if (rise) begin
                  tx_done_o <= 1'b1;
                  state_r <= sda_i ? S_IDLE : S_TXLD;
               end
               S_TXLD: if (fall) begin
                  sh_r <= tx_byte_i;
                  sda_oe_o <= ~tx_byte_i[7];
                  bitc_r <= 3'd0;
                  state_r <= S_TX;
               end
               default: state_r <= S_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* verif/gauge_cfg_bank_monitor.sv */
// port checker of the gauge configuration bank
// assumes: bound into every gauge_cfg_bank, one clock domain
`timescale 1ns/1ps
`default_nettype none
module gauge_cfg_bank_monitor (
   // clock and reset
   input wire CLK_I,
   input wire RESET_N_I,
   // bus
   input wire SCL_I,
   input wire SDA_OE_O,
   // gauging core
   input wire VOLTAGE_VALID_I,
   input wire [15:0] FINE_LEVEL_I,
   input wire [2:0] PROFILE_O,
   input wire REINIT_O,
   input wire [15:0] EMPTY_OFFSET_O,
   input wire [6:0] RELATIVE_LEVEL_O,
   input wire [15:0] CELL_TEMP_O,
   // thermistor
   input wire THERM_DONE_I,
   input wire [15:0] THERM_TEMP_I,
   input wire PULLUP_EN_O,
   input wire SAMPLE_REQ_O
);
   // done before the sample request would be a stray pulse, so only count it after
   reg req_seen_r;
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I)
         req_seen_r <= 1'b0;
      else
         req_seen_r <= PULLUP_EN_O && (req_seen_r || SAMPLE_REQ_O);
   end
   ////////////////////////////////////////
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   sda_scl_low_a: assert property ($changed(SDA_OE_O) |-> !SCL_I)
      else $error("data line moved while bus clock high");
   profile_range_a: assert property (PROFILE_O <= 3'h4)
      else $error("profile outside zero to four");
   reinit_pulse_a: assert property (REINIT_O |=> !REINIT_O)
      else $error("reinit pulse longer than one cycle");
   rel_zero_a: assert property (
      $stable(FINE_LEVEL_I) && $stable(EMPTY_OFFSET_O) && FINE_LEVEL_I == EMPTY_OFFSET_O
      |=> RELATIVE_LEVEL_O == 7'h00) else $error("relative level not zero at empty offset");
   req_in_pullup_a: assert property (
      SAMPLE_REQ_O |-> PULLUP_EN_O && $past(PULLUP_EN_O, 2))
      else $error("sample request without settled pull-up");
   pullup_off_a: assert property (
      PULLUP_EN_O && (req_seen_r || SAMPLE_REQ_O) && THERM_DONE_I
      |=> !PULLUP_EN_O && CELL_TEMP_O == $past(THERM_TEMP_I))
      else $error("measurement did not close");
   no_capture_a: assert property (
      VOLTAGE_VALID_I && (FINE_LEVEL_I <= EMPTY_OFFSET_O || CELL_TEMP_O <= 16'h0AAC)
      |=> $stable(EMPTY_OFFSET_O)) else $error("empty offset captured without cause");
   capture_val_a: assert property (
      $changed(EMPTY_OFFSET_O) && $past(VOLTAGE_VALID_I)
      |-> EMPTY_OFFSET_O == $past(FINE_LEVEL_I)) else $error("captured offset not fine level");
endmodule
bind gauge_cfg_bank gauge_cfg_bank_monitor u_mon (.CLK_I, .RESET_N_I, .SCL_I, .SDA_OE_O,
   .VOLTAGE_VALID_I, .FINE_LEVEL_I, .PROFILE_O, .REINIT_O, .EMPTY_OFFSET_O, .RELATIVE_LEVEL_O,
   .CELL_TEMP_O, .THERM_DONE_I, .THERM_TEMP_I, .PULLUP_EN_O, .SAMPLE_REQ_O);
`default_nettype wire

/* verif/gauge_cfg_bank_tb.sv */
// self-checking bench of the gauge configuration bank
// assumes: host model on the bus; bench plays gauging core and thermistor front end
`timescale 1ns/1ps
`default_nettype none
module gauge_cfg_bank_tb;
   logic clk = 1'b0, rst_n = 1'b0, vvalid = 1'b0, tdone = 1'b0, scl, sda_low, ok;
   logic [15:0] volt = 16'h0E74, fine = 16'h0000, ttemp = 16'h0C00, rd;
   logic [7:0] rc [11] = '{8'h06, 8'h0B, 8'h0C, 8'h11, 8'h12, 8'h16, 8'h1A, 8'h1C, 8'h1D,
      8'h1E, 8'h05};
   logic [15:0] rv [11] = '{16'h0D34, 16'h0000, 16'h001E, 16'h5A5A, 16'h0000, 16'h0000,
      16'hA5A5, 16'h0002, 16'h0000, 16'h0000, 16'h0000};
   wire sdo, oe, pull, req, reinit;
   wire sda = !sda_low && (!oe || sdo);
   wire [15:0] vinit, eoff, ctemp, foff, bconst;
   wire [7:0] chg, dis;
   wire [6:0] rel;
   wire [2:0] prof;
   int n_fail = 0, comparisons = 0, cyc = 0, n_re = 0, on_cnt = 0, dly = 0;
   // identity parameters are arbitrary values
   gauge_cfg_bank #(.VERSION_CODE(16'h5A5A), .PROFILES_ID(16'hA5A5),
      .THERM_PERIOD(32'h0000_00C8)) dut (.CLK_I(clk), .RESET_N_I(rst_n), .SCL_I(scl),
      .SDA_I(sda), .SDA_O(sdo), .SDA_OE_O(oe), .CELL_VOLTAGE_I(volt), .VOLTAGE_VALID_I(vvalid),
      .FINE_LEVEL_I(fine), .PROFILE_O(prof), .REINIT_O(reinit), .REINIT_VOLTAGE_O(vinit),
      .CHARGE_FIT_O(chg), .DISCHARGE_FIT_O(dis), .FULL_OFFSET_O(foff), .EMPTY_OFFSET_O(eoff),
      .RELATIVE_LEVEL_O(rel), .CELL_TEMP_O(ctemp), .THERM_DONE_I(tdone), .THERM_TEMP_I(ttemp),
      .THERM_B_O(bconst), .PULLUP_EN_O(pull), .SAMPLE_REQ_O(req));
   host_i2c_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
   always #10 clk = ~clk;
   // converter answers each sample request one cycle later
   always @(negedge clk) begin
      tdone <= req;
      n_re += reinit;
      if (req)
         dly = on_cnt;
      on_cnt = pull ? on_cnt + 1 : 0;
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         final_report();
      end
   end
   ////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      if (n_fail == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      host.write_word(c, d, 1'b0, ok);
      chk(16'(ok), 16'h0001);
   endtask
   task automatic rdc(input logic [7:0] c, input logic [15:0] e);
      host.read_word(c, rd, ok);
      chk(rd, e);
      chk(16'(ok), 16'h0001);
   endtask
   task automatic vpulse(input logic [15:0] v);
      volt = v;
      vvalid = 1'b1;
      @(negedge clk);
      vvalid = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   // waits out a running measurement, then times a fresh one
   task automatic meas(input int e);
      ttemp = ttemp + 16'h0001;
      while (pull) @(negedge clk);
      while (!req) @(negedge clk);
      repeat (3) @(negedge clk);
      chk(16'(dly >= e && dly <= e + 1), 16'h0001);
      chk(ctemp, ttemp);
      chk(16'(pull), 16'h0000);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      vpulse(16'h0E10);
      chk(vinit, 16'h0E10);
      for (int i = 0; i < 11; i++)
         rdc(rc[i], rv[i]);
      wr(8'h0B, 16'h2D13);
      chk({chg, dis}, 16'h2D13);
      wr(8'h11, 16'h0000);
      rdc(8'h11, 16'h5A5A);
      host.write_word(8'h12, 16'h0003, 1'b1, ok);
      chk(16'(prof), 16'h0000);
      wr(8'h12, 16'h0004);
      wr(8'h12, 16'h0005);
      chk(16'(prof), 16'h0004);
      chk(16'(n_re), 16'h0001);
      fine = 16'h0384;
      wr(8'h1C, 16'h001F);
      chk(foff, 16'h0000);
      chk(16'(rel), 16'h005A);
      wr(8'h1C, 16'h001E);
      chk(foff, 16'h0118);
      chk(16'(rel), 16'h0064);
      wr(8'h1C, 16'h0002);
      fine = 16'h01F4;
      wr(8'h1D, 16'h0DAC);
      vpulse(16'h0DAB);
      chk(eoff, 16'h01F4);
      chk(16'(rel), 16'h0000);
      wr(8'h1E, 16'h0064);
      chk(eoff, 16'h0064);
      wr(8'h08, 16'h0AAC);
      vpulse(16'h0D00);
      chk(eoff, 16'h0064);
      wr(8'h08, 16'h0AAD);
      vpulse(16'h0D00);
      chk(eoff, 16'h01F4);
      wr(8'h1D, 16'h0000);
      fine = 16'h0258;
      vpulse(16'h0D00);
      chk(eoff, 16'h01F4);
      wr(8'h06, 16'h0FA0);
      chk(bconst, 16'h0FA0);
      wr(8'h16, 16'h0001);
      meas(((200 + 30) * 167 + 19) / 20);
      wr(8'h0C, 16'h0000);
      meas((200 * 167 + 19) / 20);
      wr(8'h08, 16'h0B00);
      chk(ctemp, ttemp);
      final_report();
   end
endmodule
`default_nettype wire

/* verif/host_i2c_model.sv */
// host processor model: word writes and reads on the two-wire bus with a CRC-8 byte
// assumes: bench resolves the data line with a pull-up; moves only on falling clock edges
`timescale 1ns/1ps
`default_nettype none
module host_i2c_model (
   // clock
   input wire logic clk_i,
   // bus
   input wire logic sda_i,
   output logic scl_o = 1'b1,
   output logic sda_low_o = 1'b0
);
   logic [7:0] crc_r = 8'h00;
   ////////////////////////////////////////
   task automatic half;
      repeat (4) @(negedge clk_i);
   endtask
   // data moves one cycle after the clock falls, so it is never read as start or stop
   task automatic bit_io(input logic v, output logic s);
      @(negedge clk_i);
      sda_low_o = !v;
      half();
      scl_o = 1'b1;
      half();
      s = sda_i;
      scl_o = 1'b0;
   endtask
   task automatic byte_io(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
      output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], s);
         rx[i] = s;
         crc_r = {crc_r[6:0], 1'b0} ^ ((crc_r[7] ^ s) ? 8'h07 : 8'h00);
      end
      bit_io(ack, s);
      acked = !s;
   endtask
   // from idle or as a repeated start
   task automatic start_c;
      @(negedge clk_i);
      sda_low_o = 1'b0;
      half();
      scl_o = 1'b1;
      half();
      sda_low_o = 1'b1;
      half();
      scl_o = 1'b0;
   endtask
   task automatic stop_c;
      @(negedge clk_i);
      sda_low_o = 1'b1;
      half();
      scl_o = 1'b1;
      half();
      sda_low_o = 1'b0;
      half();
   endtask
   ////////////////////////////////////////
   task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, input logic bad,
      output logic ok);
      logic [7:0] rx;
      logic a0, a1, a2, a3, a4;
      crc_r = 8'h00;
      start_c();
      byte_io(8'h16, 1'b1, rx, a0);
      byte_io(cmd, 1'b1, rx, a1);
      byte_io(d[7:0], 1'b1, rx, a2);
      byte_io(d[15:8], 1'b1, rx, a3);
      byte_io(crc_r ^ {7'h00, bad}, 1'b1, rx, a4);
      stop_c();
      ok = a0 && a1 && a2 && a3 && a4;
   endtask
   task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
      logic [7:0] rx;
      logic a0, a1, a2, a3;
      crc_r = 8'h00;
      start_c();
      byte_io(8'h16, 1'b1, rx, a0);
      byte_io(cmd, 1'b1, rx, a1);
      start_c();
      byte_io(8'h17, 1'b1, rx, a2);
      byte_io(8'hFF, 1'b0, d[7:0], a3);
      byte_io(8'hFF, 1'b0, d[15:8], a3);
      byte_io(8'hFF, 1'b1, rx, a3);
      stop_c();
      // a good check byte leaves the running remainder at zero
      ok = a0 && a1 && a2 && crc_r == 8'h00;
   endtask
endmodule
`default_nettype wire
